// ### rtl/spir_top.sv
// Function
// - registers decode only in bank 0 at 0x29, 0x2A, 0x2B, 0x2C and 0x2D
// - write-only 8-bit transmit byte register, zero after reset
// - read-only 8-bit receive byte register holding the latest received byte
// - status bits 6..3: overrun, complete, tx empty, rx full; tx empty resets one
// - config bits: bit order 7, phase 2, polarity 1, enable 0, reset zero
// - order, phase, polarity taken with the enabling write, used from then on
// - overrun set when a byte lands before the previous was read; control read clears
// - complete set once a byte is fully shifted; control read clears; may interrupt
// - rx full set on receive load, cleared by reading receive byte register
// - phase 0 samples leading, changes trailing; phase 1 reverse; polarity sets idle
//
// The address-and-strobe port was decided locally.
`include "spir_cfg.svh"

module spir_top (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic bank_select_bit_i,
  input wire spir_pkg::spir_addr_t reg_addr_i,
  input wire spir_pkg::spir_data_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output spir_pkg::spir_data_t reg_rdata_o,
  output logic irq_o,
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic ss_b_i,
  output logic miso_o,
  output logic miso_oe_b_o
);
  import spir_pkg::*;

  // =====================================================
  // register access decode
  logic in_bank0;
  logic wr_tx, wr_ctl, wr_ist, wr_imsk, rd_rx, rd_ctl;
  assign in_bank0 = ~bank_select_bit_i;
  assign wr_tx = reg_wr_i & in_bank0 & (reg_addr_i == `SPIR_OFS_TX);
  assign wr_ctl = reg_wr_i & in_bank0 & (reg_addr_i == `SPIR_OFS_CTL);
  assign wr_ist = reg_wr_i & in_bank0 & (reg_addr_i == `SPIR_OFS_IST);
  assign wr_imsk = reg_wr_i & in_bank0 & (reg_addr_i == `SPIR_OFS_IMSK);
  assign rd_rx = reg_rd_i & in_bank0 & (reg_addr_i == `SPIR_OFS_RX);
  assign rd_ctl = reg_rd_i & in_bank0 & (reg_addr_i == `SPIR_OFS_CTL);

  // =====================================================
  // configuration
  logic cfg_lsbf, cfg_cpha, cfg_cpol, cfg_en;
  logic act_lsbf, act_cpha, act_cpol;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      {cfg_lsbf, cfg_cpha, cfg_cpol, cfg_en} <= `SPIR_RST_CFG;
    end else if (wr_ctl) begin
      cfg_lsbf <= reg_wdata_i[`SPIR_BIT_LSBF];
      cfg_cpha <= reg_wdata_i[`SPIR_BIT_CPHA];
      cfg_cpol <= reg_wdata_i[`SPIR_BIT_CPOL];
      cfg_en <= reg_wdata_i[`SPIR_BIT_EN];
    end
  end

  // settings in force, latched by the enabling write only
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      {act_lsbf, act_cpha, act_cpol} <= 3'h0;
    end else if (wr_ctl && !cfg_en && reg_wdata_i[`SPIR_BIT_EN]) begin
      act_lsbf <= reg_wdata_i[`SPIR_BIT_LSBF];
      act_cpha <= reg_wdata_i[`SPIR_BIT_CPHA];
      act_cpol <= reg_wdata_i[`SPIR_BIT_CPOL];
    end
  end

  // =====================================================
  // link input synchronisers
  logic [2:0] sync_a, sync_b, sync_prev;
  logic sclk_s, mosi_s, ss_b_s, sclk_p, ss_b_p;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
      sync_prev <= 3'h7;
    end else begin
      sync_a <= {sclk_i, mosi_i, ss_b_i};
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end
  assign {sclk_s, mosi_s, ss_b_s} = sync_b;
  assign sclk_p = sync_prev[2];
  assign ss_b_p = sync_prev[0];

  // =====================================================
  // edge detection in the polarity-corrected clock
  logic lead_edge, trail_edge, sample_edge, change_edge, sel_fall, selected;
  assign selected = cfg_en & ~ss_b_s;
  assign sel_fall = cfg_en & ss_b_p & ~ss_b_s;
  assign lead_edge = selected & ((sclk_s ^ act_cpol) & ~(sclk_p ^ act_cpol));
  assign trail_edge = selected & (~(sclk_s ^ act_cpol) & (sclk_p ^ act_cpol));
  assign sample_edge = act_cpha ? trail_edge : lead_edge;
  assign change_edge = act_cpha ? lead_edge : trail_edge;

  // =====================================================
  // transmit buffer
  spir_data_t tx_buf;
  logic tx_empty, tx_load;
  spir_link_t link_state;
  logic [2:0] bit_cnt;
  logic byte_done;
  assign byte_done = sample_edge & (bit_cnt == `SPIR_LAST_BIT);
  assign tx_load = sel_fall | byte_done;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      tx_buf <= `SPIR_RST_TX;
    end else if (wr_tx && cfg_en) begin
      tx_buf <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      tx_empty <= `SPIR_RST_TXE;
    end else if (!cfg_en) begin
      tx_empty <= 1'b1;
    end else if (wr_tx) begin
      tx_empty <= 1'b0;
    end else if (tx_load) begin
      tx_empty <= 1'b1;
    end
  end

  // =====================================================
  // shifter
  spir_data_t tx_sh, rx_sh, next_rx, load_byte;
  logic out_bit;
  assign load_byte = tx_empty ? `SPIR_IDLE_TX : tx_buf;
  assign next_rx = act_lsbf ? {mosi_s, rx_sh[7:1]} : {rx_sh[6:0], mosi_s};

  function automatic logic first_bit(input spir_data_t d, input logic lsbf);
    first_bit = lsbf ? d[0] : d[7];
  endfunction

  function automatic spir_data_t shift_out(input spir_data_t d, input logic lsbf);
    shift_out = lsbf ? {1'b0, d[7:1]} : {d[6:0], 1'b0};
  endfunction

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      link_state <= SPIR_IDLE;
    end else begin
      case (link_state)
        SPIR_IDLE: if (sel_fall) link_state <= SPIR_BUSY;
        SPIR_BUSY: if (!selected) link_state <= SPIR_IDLE;
        default: link_state <= SPIR_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || !selected) begin
      bit_cnt <= 3'h0;
    end else if (sample_edge) begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rx_sh <= 8'h00;
    end else if (sample_edge) begin
      rx_sh <= next_rx;
    end
  end

  // phase 0 shows the first bit at select; otherwise the change edge shows it
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      tx_sh <= 8'h00;
      out_bit <= 1'b0;
    end else if (sel_fall && !act_cpha) begin
      out_bit <= first_bit(load_byte, act_lsbf);
      tx_sh <= shift_out(load_byte, act_lsbf);
    end else if (tx_load) begin
      tx_sh <= load_byte;
    end else if (change_edge) begin
      out_bit <= first_bit(tx_sh, act_lsbf);
      tx_sh <= shift_out(tx_sh, act_lsbf);
    end
  end

  assign miso_o = out_bit;
  assign miso_oe_b_o = ~(link_state == SPIR_BUSY);

  // =====================================================
  // receive register and status flags
  spir_data_t rx_data;
  logic rx_full, overrun, complete;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rx_data <= `SPIR_RST_RX;
    end else if (byte_done) begin
      rx_data <= next_rx;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rx_full <= 1'b0;
    end else if (byte_done) begin
      rx_full <= 1'b1;
    end else if (rd_rx) begin
      rx_full <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      overrun <= 1'b0;
    end else if (byte_done && rx_full && !rd_rx) begin
      overrun <= 1'b1;
    end else if (rd_ctl) begin
      overrun <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      complete <= 1'b0;
    end else if (byte_done) begin
      complete <= 1'b1;
    end else if (rd_ctl) begin
      complete <= 1'b0;
    end
  end

  // =====================================================
  // interrupt status and mask
  logic [3:0] irq_evt, irq_stat, irq_mask;
  assign irq_evt[`SPIR_IRQ_OVR] = byte_done & rx_full & ~rd_rx;
  assign irq_evt[`SPIR_IRQ_CMPL] = byte_done;
  assign irq_evt[`SPIR_IRQ_TXE] = tx_load & ~tx_empty & cfg_en;
  assign irq_evt[`SPIR_IRQ_RXF] = byte_done;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_irq
      always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
          irq_stat[gi] <= 1'b0;
        end else if (irq_evt[gi]) begin
          irq_stat[gi] <= 1'b1;
        end else if (wr_ist && reg_wdata_i[gi]) begin
          irq_stat[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      irq_mask <= `SPIR_RST_IRQ;
    end else if (wr_imsk) begin
      irq_mask <= reg_wdata_i[3:0];
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

  // =====================================================
  // read data
  spir_data_t ctl_view;
  always_comb begin
    ctl_view = 8'h00;
    ctl_view[`SPIR_BIT_LSBF] = cfg_lsbf;
    ctl_view[`SPIR_BIT_OVR] = overrun;
    ctl_view[`SPIR_BIT_CMPL] = complete;
    ctl_view[`SPIR_BIT_TXE] = tx_empty;
    ctl_view[`SPIR_BIT_RXF] = rx_full;
    ctl_view[`SPIR_BIT_CPHA] = cfg_cpha;
    ctl_view[`SPIR_BIT_CPOL] = cfg_cpol;
    ctl_view[`SPIR_BIT_EN] = cfg_en;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i && in_bank0) begin
      case (reg_addr_i)
        `SPIR_OFS_RX: reg_rdata_o <= rx_data;
        `SPIR_OFS_CTL: reg_rdata_o <= ctl_view;
        `SPIR_OFS_IST: reg_rdata_o <= {4'h0, irq_stat};
        `SPIR_OFS_IMSK: reg_rdata_o <= {4'h0, irq_mask};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_bank_decode: assert property (bank_select_bit_i |=> reg_rdata_o == 8'h00)
    else $error("register decoded outside bank 0");
  chk_tx_hold: assert property (wr_tx && cfg_en |=> tx_buf == $past(reg_wdata_i))
    else $error("transmit byte not stored");
  chk_rx_load: assert property (byte_done |=> rx_data == $past(next_rx) && rx_full)
    else $error("receive byte not loaded");
  chk_txe_disabled: assert property (!cfg_en |=> tx_empty)
    else $error("tx empty low while disabled");
  chk_txe_write: assert property (wr_tx && cfg_en |=> !tx_empty)
    else $error("tx empty still set after transmit write");
  chk_cfg_latch: assert property (
      wr_ctl && !cfg_en && reg_wdata_i[0] |=> act_cpha == $past(reg_wdata_i[2]))
    else $error("phase not taken with enable");
  chk_cfg_frozen: assert property (cfg_en && $past(cfg_en) |-> $stable(act_cpol))
    else $error("settings changed while enabled");
  chk_ovr_set: assert property (byte_done && rx_full && !rd_rx |=> overrun)
    else $error("overrun not flagged");
  chk_cmpl_clear: assert property (rd_ctl && !byte_done |=> !complete)
    else $error("complete not cleared by control read");
  chk_ovr_clear: assert property (rd_ctl && !byte_done |=> !overrun)
    else $error("overrun not cleared by control read");
  chk_cmpl_set: assert property (byte_done |=> complete)
    else $error("complete not set after last bit");
  chk_rxf_clear: assert property (rd_rx && !byte_done |=> !rx_full)
    else $error("rx full not cleared by read");
  chk_sample_edge: assert property (
      sample_edge |-> $changed(sclk_s) && ((sclk_s ^ act_cpol) != act_cpha))
    else $error("sample on wrong edge");
  chk_miso_change: assert property ($changed(miso_o) |-> $past(change_edge || sel_fall))
    else $error("serial output changed off a change edge");
  chk_irq_level: assert property (
      byte_done && irq_mask[`SPIR_IRQ_CMPL] && !wr_imsk |=> irq_o)
    else $error("interrupt output low with pending cause");

  cov_byte_rx: cover property (byte_done);
  cov_overrun: cover property (byte_done && rx_full);
  cov_phase1: cover property (act_cpha && byte_done);
  cov_irq: cover property (irq_o);

endmodule // spir_top

// ### common/spir_cfg.svh
`ifndef SPIR_CFG_SVH
`define SPIR_CFG_SVH

// =====================================================
// register offsets, bank 0
`define SPIR_OFS_TX 8'h29
`define SPIR_OFS_RX 8'h2A
`define SPIR_OFS_CTL 8'h2B
`define SPIR_OFS_IST 8'h2C
`define SPIR_OFS_IMSK 8'h2D

// =====================================================
// control/status field positions
`define SPIR_BIT_LSBF 7
`define SPIR_BIT_OVR 6
`define SPIR_BIT_CMPL 5
`define SPIR_BIT_TXE 4
`define SPIR_BIT_RXF 3
`define SPIR_BIT_CPHA 2
`define SPIR_BIT_CPOL 1
`define SPIR_BIT_EN 0

// =====================================================
// interrupt status/mask field positions
`define SPIR_IRQ_OVR 0
`define SPIR_IRQ_CMPL 1
`define SPIR_IRQ_TXE 2
`define SPIR_IRQ_RXF 3

// =====================================================
// reset values, idle transmit byte and last bit index
`define SPIR_RST_TX 8'h00
`define SPIR_RST_RX 8'h00
`define SPIR_RST_CFG 4'h0
`define SPIR_RST_TXE 1'b1
`define SPIR_RST_IRQ 4'h0
`define SPIR_IDLE_TX 8'h00
`define SPIR_LAST_BIT 3'h7

`endif

// ### common/spir_pkg.sv
package spir_pkg;
  typedef logic [7:0] spir_addr_t;
  typedef logic [7:0] spir_data_t;
  typedef enum logic {SPIR_IDLE, SPIR_BUSY} spir_link_t;
endpackage : spir_pkg

// ### verification/spir_peer.sv
// ====
// bus master peer on the serial link
module spir_peer (
  output logic sclk_o,
  output logic mosi_o,
  output logic ss_b_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk_o = 1'b0;
    mosi_o = 1'b1;
    ss_b_o = 1'b1;
  end
  // cfg is {order, phase, polarity}; clock still between frames
  task automatic xfer(input logic [7:0] tx, input logic [2:0] cfg, output logic [7:0] rx);
    int b;
    sclk_o = cfg[0];
    #400 ss_b_o = 1'b0;
    #400;
    for (int i = 0; i < 8; i++) begin
      b = cfg[2] ? i : 7 - i;
      if (!cfg[1]) mosi_o = tx[b];
      #200 sclk_o = ~cfg[0];
      if (cfg[1]) mosi_o = tx[b];
      else rx[b] = miso_i;
      #200 sclk_o = cfg[0];
      if (cfg[1]) rx[b] = miso_i;
    end
    #400 ss_b_o = 1'b1;
    mosi_o = ~mosi_o;
  endtask
endmodule // spir_peer

// ### verification/spir_top_tb.sv
module spir_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import spir_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic bank = 1'b0;
  logic bk = 1'b0;
  spir_addr_t addr = 8'h00;
  spir_data_t wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  spir_data_t rdata;
  logic irq;
  logic sclk;
  logic mosi;
  logic ss_b;
  logic miso;
  logic miso_oe_b;
  logic miso_w;
  logic [7:0] got;
  int n_fail = 0;
  int n_tests = 0;
  always #25 clk = ~clk;
  // released line has a pull-up
  assign miso_w = miso_oe_b ? 1'b1 : miso;
  spir_top i_spir_top (.ref_clk_i(clk), .rst_b_i(rst_b), .bank_select_bit_i(bank),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .irq_o(irq), .sclk_i(sclk), .mosi_i(mosi), .ss_b_i(ss_b),
    .miso_o(miso), .miso_oe_b_o(miso_oe_b));
  spir_peer i_spir_peer (.sclk_o(sclk), .mosi_o(mosi), .ss_b_o(ss_b), .miso_i(miso_w));
  // ====
  // bus tasks
  task automatic chk(input spir_data_t seen, input spir_data_t exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input spir_addr_t a, input spir_data_t d);
    @(posedge clk);
    bank <= bk;
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input spir_addr_t a, input spir_data_t exp);
    @(posedge clk);
    bank <= bk;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic complete_run();
    $display("TB: tests=%0d errors=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ====
  // scenarios
  task automatic t_reset_idle();
    rd_chk(8'h2B, 8'h10);
    rd_chk(8'h2A, 8'h00);
    rd_chk(8'h29, 8'h00);
    rd_chk(8'h2C, 8'h00);
    i_spir_peer.xfer(8'h5A, 3'h0, got);
    rd_chk(8'h2B, 8'h10);
    rd_chk(8'h2A, 8'h00);
    chk({7'h00, miso_oe_b}, 8'h01);
  endtask
  task automatic t_bank();
    bk = 1'b1;
    wreg(8'h2B, 8'h87);
    rd_chk(8'h2B, 8'h00);
    bk = 1'b0;
    rd_chk(8'h2B, 8'h10);
    rd_chk(8'h28, 8'h00);
  endtask
  task automatic t_modes();
    spir_data_t ctl;
    spir_data_t d;
    for (int c = 0; c < 8; c++) begin
      ctl = {c[2], 4'h0, c[1], c[0], 1'b1};
      d = 8'h96 + 8'(c);
      wreg(8'h2B, ctl);
      wreg(8'h29, d);
      i_spir_peer.xfer(~d, c[2:0], got);
      chk(got, d);
      rd_chk(8'h2B, ctl | 8'h38);
      rd_chk(8'h2A, ~d);
      rd_chk(8'h2B, ctl | 8'h10);
      wreg(8'h2B, 8'h00);
    end
  endtask
  task automatic t_overrun();
    wreg(8'h2B, 8'h01);
    wreg(8'h29, 8'h3C);
    i_spir_peer.xfer(8'h11, 3'h0, got);
    i_spir_peer.xfer(8'h22, 3'h0, got);
    chk(got, 8'h00);
    rd_chk(8'h2B, 8'h79);
    rd_chk(8'h2B, 8'h19);
    rd_chk(8'h2A, 8'h22);
    rd_chk(8'h2C, 8'h0F);
  endtask
  task automatic t_irq();
    wreg(8'h2C, 8'h0F);
    wreg(8'h2D, 8'h02);
    chk({7'h00, irq}, 8'h00);
    wreg(8'h29, 8'h5A);
    i_spir_peer.xfer(8'h33, 3'h0, got);
    chk({7'h00, irq}, 8'h01);
    rd_chk(8'h2C, 8'h0E);
    wreg(8'h2D, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wreg(8'h2C, 8'h02);
    wreg(8'h2D, 8'h02);
    chk({7'h00, irq}, 8'h00);
    rd_chk(8'h2C, 8'h0C);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset_idle();
    t_bank();
    t_modes();
    t_overrun();
    t_irq();
    complete_run();
  end
endmodule // spir_top_tb
